// *** shared/sfod_pkg.sv ***
// opcode values, bank register layout and command queue entry layout
// assumes one 100 MHz system clock; the serial link is sampled, not clocked
package sfod_pkg;
    // ==========================================================
    // three-byte-form opcodes (four-byte when wide addressing is on)
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_QUICK_READ = 8'h0B;
    localparam logic [7:0] OP_TWO_LANE_OUT_READ = 8'h3B;
    localparam logic [7:0] OP_FOUR_LANE_OUT_READ = 8'h6B;
    localparam logic [7:0] OP_TWO_LANE_IO_READ = 8'hBB;
    localparam logic [7:0] OP_FOUR_LANE_IO_READ = 8'hEB;
    localparam logic [7:0] OP_DTR_FAST_READ = 8'h0D;
    localparam logic [7:0] OP_DTR_TWO_LANE_IO_READ = 8'hBD;
    localparam logic [7:0] OP_DTR_FOUR_LANE_IO_READ = 8'hED;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OP_FOUR_LANE_PAGE_WRITE = 8'h32;
    localparam logic [7:0] OP_FOUR_LANE_PAGE_WRITE_ALT = 8'h38;
    localparam logic [7:0] OP_SMALL_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
    // ==========================================================
    // native four-byte opcodes
    localparam logic [7:0] OP_WIDE_ADDR_READ = 8'h13;
    localparam logic [7:0] OP_WIDE_ADDR_QUICK_READ = 8'h0C;
    localparam logic [7:0] OP_WIDE_ADDR_DTR_READ = 8'h0E;
    localparam logic [7:0] OP_WIDE_ADDR_TWO_LANE_OUT_READ = 8'h3C;
    localparam logic [7:0] OP_WIDE_ADDR_FOUR_LANE_OUT_READ = 8'h6C;
    localparam logic [7:0] OP_WIDE_TWO_LANE_IO_READ = 8'hBC;
    localparam logic [7:0] OP_WIDE_FOUR_LANE_IO_READ = 8'hEC;
    localparam logic [7:0] OP_WIDE_DTR_TWO_LANE_IO_READ = 8'hBE;
    localparam logic [7:0] OP_WIDE_DTR_FOUR_LANE_IO_READ = 8'hEE;
    localparam logic [7:0] OP_WIDE_PAGE_WRITE = 8'h12;
    localparam logic [7:0] OP_WIDE_FOUR_LANE_PAGE_WRITE = 8'h34;
    localparam logic [7:0] OP_WIDE_SMALL_SECTOR_ERASE = 8'h21;
    localparam logic [7:0] OP_WIDE_SECTOR_ERASE = 8'hDC;
    localparam logic [7:0] OP_CORRECTION_STATUS_READ = 8'h18;
    // ==========================================================
    // commands without an address
    localparam logic [7:0] OP_MAKER_SIGNATURE_READ = 8'h90;
    localparam logic [7:0] OP_IDENTIFICATION_READ = 8'h9F;
    localparam logic [7:0] OP_SIGNATURE_READ = 8'hAB;
    localparam logic [7:0] OP_BANK_REG_READ = 8'h16;
    localparam logic [7:0] OP_BANK_REG_WRITE = 8'h17;
    localparam logic [7:0] OP_BANK_ACCESS_LEGACY = 8'hB9;
    localparam logic [7:0] OP_LEARNING_PATTERN_READ = 8'h41;
    localparam logic [7:0] OP_LEARNING_PATTERN_NV_WRITE = 8'h43;
    localparam logic [7:0] OP_LEARNING_PATTERN_VOL_WRITE = 8'h4A;
    // ==========================================================
    // bank register
    localparam logic [7:0] BANK_RESET = 8'h00;
    localparam int WIDE_ADDRESS_ENABLE_BIT = 7;
    localparam logic [7:0] BANK_ADDR_MASK = 8'h7F;
    localparam logic [31:0] ARRAY_LAST_DEFAULT = 32'h01FF_FFFF;
    // ==========================================================
    // queue entry: kind, opcode, address, data byte
    localparam logic KIND_CMD = 1'b0;
    localparam logic KIND_DATA = 1'b1;
    localparam int ENTRY_W = 49;
    localparam int QUEUE_DEPTH = 32;
endpackage : sfod_pkg

// *** shared/sfod_if.sv ***
// valid/ready carrier from the decoder into the command queue
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface sfod_if #(parameter int W = 49);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sfod_if

// *** verilog/sfod_sync.sv ***
// two-flop synchroniser for a group of asynchronous pins
// assumes the pins change slowly compared with clk
`timescale 1ns/1ps
module sfod_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sfod_sync_s;
    sfod_sync_s r;
    sfod_sync_s next_r;
    always_comb begin
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= {INIT, INIT};
        end else begin
            r <= next_r;
        end
    end
    assign q = r.s2;
endmodule : sfod_sync

// *** verilog/sfod_fifo.sv ***
// synchronous valid/ready queue, power-of-two depth
// assumes fill and drain share clk
`timescale 1ns/1ps
module sfod_fifo #(
    parameter int W = 49,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    sfod_if.snk fill,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("queue depth must be a power of two, at least 2");
    end
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] count;
    } sfod_fifo_s;
    sfod_fifo_s r;
    sfod_fifo_s next_r;
    logic [W-1:0] mem [DEPTH];
    logic do_push;
    logic do_pop;
    assign fill.ready = (r.count != DEPTH[AW:0]);
    assign out_valid = (r.count != '0);
    assign out_data = mem[r.rp];
    assign do_push = fill.valid && fill.ready;
    assign do_pop = out_valid && out_ready;
    always_comb begin
        next_r = r;
        if (do_push) begin
            next_r.wp = r.wp + 1'b1;
        end
        if (do_pop) begin
            next_r.rp = r.rp + 1'b1;
        end
        next_r.count = r.count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[r.wp] <= fill.data;
        end
    end
endmodule : sfod_fifo

// *** verilog/sfod_top.sv ***
// serial flash instruction decoder and start-address former
// assumes a host in clock mode 0 or 3, sck well below clk/4; pins arrive asynchronously
`timescale 1ns/1ps
module sfod_top
    import sfod_pkg::*;
#(
    parameter logic [31:0] ARRAY_LAST = sfod_pkg::ARRAY_LAST_DEFAULT,
    parameter int DEPTH = sfod_pkg::QUEUE_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe_n,
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic cmd_kind,
    output logic [7:0] cmd_opcode,
    output logic [31:0] cmd_addr,
    output logic [7:0] cmd_byte,
    output logic [31:0] read_addr,
    output logic read_next,
    output logic [7:0] bank_select,
    output logic overrun,
    input wire logic overrun_clr
);
    import sfod_pkg::*;

    if (DEPTH < 2) begin : g_chk
        $error("queue depth must be at least 2");
    end

    // the step function wraps at the last byte, so a one-byte array cannot stream
    if (ARRAY_LAST == 32'h0000_0000) begin : g_chk_last
        $error("array must hold at least two bytes");
    end

    // ==========================================================
    // reset release
    // asynchronous assert, clocked release, so no flop leaves reset on a late edge
    logic [1:0] rst_sync;
    logic rst_loc_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_loc_n = rst_sync[1];

    // ==========================================================
    // pin sampling
    // all three pins share one synchroniser, so si keeps its place against sck
    logic [2:0] pins_s;
    logic sck_s;
    logic cs_n_s;
    logic si_s;
    sfod_sync #(.W(3), .INIT(3'b010)) u_sync (
        .clk(clk),
        .rst_n(rst_loc_n),
        .d({sck, cs_n, si}),
        .q(pins_s)
    );
    assign sck_s = pins_s[2];
    assign cs_n_s = pins_s[1];
    assign si_s = pins_s[0];

    // ==========================================================
    // decode helpers
    function automatic logic is_wide_op(input logic [7:0] op);
        case (op)
            OP_WIDE_ADDR_READ, OP_WIDE_ADDR_QUICK_READ, OP_WIDE_ADDR_DTR_READ,
            OP_WIDE_ADDR_TWO_LANE_OUT_READ, OP_WIDE_ADDR_FOUR_LANE_OUT_READ,
            OP_WIDE_TWO_LANE_IO_READ, OP_WIDE_FOUR_LANE_IO_READ,
            OP_WIDE_DTR_TWO_LANE_IO_READ, OP_WIDE_DTR_FOUR_LANE_IO_READ,
            OP_WIDE_PAGE_WRITE, OP_WIDE_FOUR_LANE_PAGE_WRITE,
            OP_WIDE_SMALL_SECTOR_ERASE, OP_WIDE_SECTOR_ERASE,
            OP_CORRECTION_STATUS_READ: is_wide_op = 1'b1;
            default: is_wide_op = 1'b0;
        endcase
    endfunction : is_wide_op

    function automatic logic is_short_op(input logic [7:0] op);
        case (op)
            OP_READ, OP_QUICK_READ, OP_TWO_LANE_OUT_READ, OP_FOUR_LANE_OUT_READ,
            OP_TWO_LANE_IO_READ, OP_FOUR_LANE_IO_READ,
            OP_DTR_FAST_READ, OP_DTR_TWO_LANE_IO_READ,
            OP_DTR_FOUR_LANE_IO_READ: is_short_op = 1'b1;
            OP_PAGE_WRITE, OP_FOUR_LANE_PAGE_WRITE,
            OP_FOUR_LANE_PAGE_WRITE_ALT: is_short_op = 1'b1;
            OP_SMALL_SECTOR_ERASE: is_short_op = 1'b1;
            OP_SECTOR_ERASE: is_short_op = 1'b1;
            default: is_short_op = 1'b0;
        endcase
    endfunction : is_short_op

    function automatic logic is_plain_op(input logic [7:0] op);
        case (op)
            OP_MAKER_SIGNATURE_READ, OP_IDENTIFICATION_READ,
            OP_SIGNATURE_READ: is_plain_op = 1'b1;
            OP_LEARNING_PATTERN_READ, OP_LEARNING_PATTERN_NV_WRITE,
            OP_LEARNING_PATTERN_VOL_WRITE: is_plain_op = 1'b1;
            OP_BANK_REG_READ, OP_BANK_REG_WRITE,
            OP_BANK_ACCESS_LEGACY: is_plain_op = 1'b1;
            default: is_plain_op = 1'b0;
        endcase
    endfunction : is_plain_op

    // data bytes that follow go into the queue at counting addresses
    function automatic logic is_write_op(input logic [7:0] op);
        case (op)
            OP_PAGE_WRITE, OP_FOUR_LANE_PAGE_WRITE, OP_FOUR_LANE_PAGE_WRITE_ALT,
            OP_WIDE_PAGE_WRITE, OP_WIDE_FOUR_LANE_PAGE_WRITE,
            OP_LEARNING_PATTERN_NV_WRITE, OP_LEARNING_PATTERN_VOL_WRITE: is_write_op = 1'b1;
            default: is_write_op = 1'b0;
        endcase
    endfunction : is_write_op

    // erases, writes and the status read never stream
    function automatic logic is_array_read(input logic [7:0] op);
        is_array_read = (is_short_op(op) || is_wide_op(op)) && !is_write_op(op)
            && op != OP_SMALL_SECTOR_ERASE && op != OP_SECTOR_ERASE
            && op != OP_WIDE_SMALL_SECTOR_ERASE && op != OP_WIDE_SECTOR_ERASE
            && op != OP_CORRECTION_STATUS_READ;
    endfunction : is_array_read

    // sequential address, wrapping to zero past the array end
    function automatic logic [31:0] step_addr(input logic [31:0] a);
        step_addr = (a >= ARRAY_LAST) ? 32'h0000_0000 : a + 32'h0000_0001;
    endfunction : step_addr

    // ==========================================================
    // decoder state
    typedef enum logic [4:0] {
        ST_OPC = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_DATA = 5'b00100,
        ST_BANKRD = 5'b01000,
        ST_IGN = 5'b10000
    } sfod_state_e;

    typedef struct packed {
        sfod_state_e state;
        logic sck_d;
        logic [2:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] opcode;
        logic wide;
        logic [2:0] need;
        logic [31:0] addr;
        logic [7:0] bank;
        logic so;
        logic so_oe_n;
        logic push;
        logic [ENTRY_W-1:0] entry;
        logic read_next;
        logic overrun;
    } sfod_top_s;

    sfod_top_s r;
    sfod_top_s next_r;
    sfod_if #(.W(ENTRY_W)) q_if ();

    // a false rise after reset in mode 3 is harmless: synced cs_n still reads high
    logic sck_rise;
    logic sck_fall;
    assign sck_rise = sck_s && !r.sck_d;
    assign sck_fall = !sck_s && r.sck_d;

    always_comb begin
        logic [7:0] byte_in;
        logic [31:0] start;
        logic want_push;
        logic [ENTRY_W-1:0] want_entry;
        byte_in = {r.shreg[6:0], si_s};
        start = 32'h0000_0000;
        want_push = 1'b0;
        want_entry = '0;
        next_r = r;
        next_r.sck_d = sck_s;
        next_r.push = 1'b0;
        next_r.read_next = 1'b0;
        if (cs_n_s) begin
            // frame over: the next falling chip select starts a fresh opcode
            next_r.state = ST_OPC;
            next_r.bitcnt = 3'd0;
            next_r.so_oe_n = 1'b1;
        end else begin
            if (sck_rise) begin
                next_r.shreg = byte_in;
                next_r.bitcnt = r.bitcnt + 3'd1;
                if (r.bitcnt == 3'd7) begin
                    case (r.state)
                        ST_OPC: begin
                            next_r.opcode = byte_in;
                            next_r.addr = 32'h0000_0000;
                            next_r.wide = is_wide_op(byte_in)
                                || r.bank[WIDE_ADDRESS_ENABLE_BIT];
                            if (is_wide_op(byte_in)) begin
                                next_r.need = 3'd4;
                                next_r.state = ST_ADDR;
                            end else if (is_short_op(byte_in)) begin
                                next_r.need = r.bank[WIDE_ADDRESS_ENABLE_BIT]
                                    ? 3'd4 : 3'd3;
                                next_r.state = ST_ADDR;
                            end else if (is_plain_op(byte_in)) begin
                                want_push = 1'b1;
                                want_entry = {KIND_CMD, byte_in, 32'h0000_0000, 8'h00};
                                next_r.state = (byte_in == OP_BANK_REG_READ)
                                    ? ST_BANKRD : ST_DATA;
                            end else begin
                                next_r.state = ST_IGN;
                            end
                        end
                        ST_ADDR: begin
                            next_r.addr = {r.addr[23:0], byte_in};
                            next_r.need = r.need - 3'd1;
                            if (r.need == 3'd1) begin
                                if (r.wide) begin
                                    start = {r.addr[23:0], byte_in};
                                end else begin
                                    // top byte from the bank, offset from the command
                                    start = {r.bank & BANK_ADDR_MASK,
                                        r.addr[15:0], byte_in};
                                end
                                next_r.addr = start;
                                want_push = 1'b1;
                                want_entry = {KIND_CMD, r.opcode, start, 8'h00};
                                next_r.state = ST_DATA;
                            end
                        end
                        ST_DATA: begin
                            if (r.opcode == OP_BANK_REG_WRITE
                                || r.opcode == OP_BANK_ACCESS_LEGACY) begin
                                next_r.bank = byte_in;
                                next_r.state = ST_IGN;
                            end else if (is_write_op(r.opcode)) begin
                                want_push = 1'b1;
                                want_entry = {KIND_DATA, r.opcode, r.addr, byte_in};
                                next_r.addr = step_addr(r.addr);
                            end else if (is_array_read(r.opcode)) begin
                                // counts on its own; the bank is never rewritten here
                                next_r.addr = step_addr(r.addr);
                                next_r.read_next = 1'b1;
                            end else begin
                                next_r.state = ST_IGN;
                            end
                        end
                        default: begin
                            next_r.state = r.state;
                        end
                    endcase
                end
            end
            if (sck_fall && r.state == ST_BANKRD) begin
                // bit index 7 - bitcnt: msb first, repeats every byte
                next_r.so = r.bank[~r.bitcnt];
                next_r.so_oe_n = 1'b0;
            end
        end
        // a full queue cannot stall the host, so the rest of the frame is dropped instead
        if (want_push && q_if.ready) begin
            next_r.push = 1'b1;
            next_r.entry = want_entry;
        end
        // a drop in the same cycle as a clear keeps the flag set
        if (want_push && !q_if.ready) begin
            next_r.overrun = 1'b1;
            next_r.state = ST_IGN;
        end else if (overrun_clr) begin
            next_r.overrun = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_loc_n) begin
        if (!rst_loc_n) begin
            r <= '{state: ST_OPC, sck_d: 1'b0, bitcnt: 3'd0, shreg: 8'h00,
                opcode: 8'h00, wide: 1'b0, need: 3'd0, addr: 32'h0000_0000,
                bank: BANK_RESET, so: 1'b0, so_oe_n: 1'b1, push: 1'b0,
                entry: '0, read_next: 1'b0, overrun: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // ==========================================================
    // command queue
    assign q_if.valid = r.push;
    assign q_if.data = r.entry;

    logic [ENTRY_W-1:0] q_out;
    sfod_fifo #(.W(ENTRY_W), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_loc_n),
        .fill(q_if),
        .out_valid(cmd_valid),
        .out_ready(cmd_ready),
        .out_data(q_out)
    );

    // ==========================================================
    // outputs
    // the queue head is sliced straight from the flop array, no extra stage
    assign cmd_kind = q_out[48];
    assign cmd_opcode = q_out[47:40];
    assign cmd_addr = q_out[39:8];
    assign cmd_byte = q_out[7:0];
    assign read_addr = r.addr;
    assign read_next = r.read_next;
    assign bank_select = r.bank;
    assign overrun = r.overrun;
    assign so = r.so;
    assign so_oe_n = r.so_oe_n;
endmodule : sfod_top

// *** verification/sfod_top_properties.sv ***
// concurrent checks on the decoder top ports
// assumes the bind below attaches it to the decoder top
`timescale 1ns/1ps
module sfod_top_properties
    import sfod_pkg::*;
#(
    parameter logic [31:0] ARRAY_LAST = sfod_pkg::ARRAY_LAST_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic cmd_kind,
    input wire logic [7:0] cmd_opcode,
    input wire logic [31:0] cmd_addr,
    input wire logic [7:0] cmd_byte,
    input wire logic [31:0] read_addr,
    input wire logic read_next,
    input wire logic [7:0] bank_select
);
    // ==========================================================
    // properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_idle;
        cs_n [*6];
    endsequence
    sequence s_held;
        cmd_valid && !cmd_ready;
    endsequence
    a_bank_reset_zero: assert property ($rose(rst_n) |-> bank_select == 8'h00)
        else $error("bank register not zero after reset");
    a_read_step_one: assert property (read_next
        |-> read_addr == $past(read_addr) + 32'h1
        || (read_addr == 32'h0 && $past(read_addr) == ARRAY_LAST))
        else $error("read address did not step by one");
    a_bank_read_kept: assert property (read_next |-> $stable(bank_select))
        else $error("bank register moved during read");
    a_bank_idle_kept: assert property (s_idle |-> $stable(bank_select))
        else $error("bank register moved outside a frame");
    a_entry_stands: assert property (s_held |=> cmd_valid
        && $stable({cmd_kind, cmd_opcode, cmd_addr, cmd_byte}))
        else $error("queue head changed before pop");
    a_cmd_byte_zero: assert property (cmd_valid && cmd_kind == KIND_CMD
        |-> cmd_byte == 8'h00)
        else $error("command entry carries a data byte");
    a_data_op_kind: assert property (cmd_valid && cmd_kind == KIND_DATA
        |-> cmd_opcode inside {8'h02, 8'h32, 8'h38, 8'h12, 8'h34, 8'h43, 8'h4A})
        else $error("data entry under a non-write opcode");
    a_id_no_addr: assert property (cmd_valid && cmd_kind == KIND_CMD
        && cmd_opcode inside {8'h90, 8'h9F, 8'hAB, 8'h41} |-> cmd_addr == 32'h0)
        else $error("address-less command has an address");
endmodule : sfod_top_properties
bind sfod_top sfod_top_properties #(.ARRAY_LAST(ARRAY_LAST)) u_sfod_top_properties (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_kind(cmd_kind), .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_byte(cmd_byte),
    .read_addr(read_addr), .read_next(read_next), .bank_select(bank_select));

// *** verification/sfod_host.sv ***
// host side of the serial link: whole-byte frames, clock mode 0
// assumes the decoder samples these pins with its own clock
`timescale 1ns/1ps
module sfod_host (
    input wire logic so,
    input wire logic so_oe_n,
    output logic sck,
    output logic cs_n,
    output logic si
);
    // ==========================================================
    // frame driver
    // bits seen on so at each sck rise; an undriven so reads inverted
    logic [7:0] rx;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        rx = 8'h00;
    end
    // 80 ns sck keeps every opcode class inside its rate limit
    // pins move 1 ns after a clk edge; a frame lasts whole clk periods
    task automatic frame(input logic [7:0] b[$]);
        #1 cs_n = 1'b0;
        foreach (b[i]) begin
            for (int k = 7; k >= 0; k--) begin
                si = b[i][k];
                #40 sck = 1'b1;
                rx = {rx[6:0], so_oe_n ? ~so : so};
                #40 sck = 1'b0;
            end
        end
        #40 cs_n = 1'b1;
        // released line flips so a stale bit cannot pass for data
        si = ~si;
        #99;
    endtask : frame
endmodule : sfod_host

// *** verification/sfod_top_tb.sv ***
// self-checking bench: host frames in, queue entries out
// assumes the host model and the checker are compiled first
`timescale 1ns/1ps
module sfod_top_tb;
    import sfod_pkg::*;
    logic clk, rst_n, sck, cs_n, si, so, so_oe_n, cmd_valid, cmd_ready, cmd_kind;
    logic read_next, overrun, overrun_clr, hold;
    logic [7:0] cmd_opcode, cmd_byte, bank_select;
    logic [31:0] cmd_addr, read_addr, a;
    logic [48:0] got, want;
    logic [48:0] q[$];
    logic [7:0] ops[$];
    int err_count, checked, seed;
    // ==========================================================
    // design, host, clock
    sfod_top u_sfod_top (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
        .so_oe_n(so_oe_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
        .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_byte(cmd_byte),
        .read_addr(read_addr), .read_next(read_next), .bank_select(bank_select),
        .overrun(overrun), .overrun_clr(overrun_clr));
    sfod_host u_sfod_host (.so(so), .so_oe_n(so_oe_n), .sck(sck), .cs_n(cs_n), .si(si));
    assign got = {cmd_kind, cmd_opcode, cmd_addr, cmd_byte};
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========================================================
    // helpers
    task automatic chk_val(input logic [48:0] e, input logic [48:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk_val
    task automatic chk_reg(input logic [7:0] e, input logic [7:0] g);
        chk_val({41'h0, e}, {41'h0, g});
    endtask : chk_reg
    task automatic note(input logic [7:0] op, input logic [31:0] ad,
        input logic k = KIND_CMD, input logic [7:0] b = 8'h00);
        q.push_back({k, op, ad, b});
    endtask : note
    task automatic set_bank(input logic [7:0] op, input logic [7:0] v);
        note(op, 32'h0);
        u_sfod_host.frame('{op, v});
        chk_reg(v, bank_select);
    endtask : set_bank
    task automatic wait_empty;
        for (int i = 0; i < 5000 && q.size() != 0; i++) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask : wait_empty
    task automatic test_done;
        $display("checked %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // ==========================================================
    // queue side: random stalls, oldest note against each pop
    always @(posedge clk) begin
        #1;
        cmd_ready = hold ? 1'b0 : 1'($random(seed));
    end
    // mid-cycle look: the head and cmd_ready here are what the next edge pops
    always @(negedge clk)
        if (rst_n === 1'b1 && cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
            want = q.size() ? q.pop_front() : '0;
            chk_val(want, got);
        end
    initial begin
        #500000;
        err_count++;
        test_done;
    end
    // ==========================================================
    // scenarios
    initial begin
        rst_n = 1'b0;
        cmd_ready = 1'b0;
        overrun_clr = 1'b0;
        hold = 1'b0;
        err_count = 0;
        checked = 0;
        seed = 32'h47e4b8d3;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (10) @(posedge clk);
        chk_reg(8'h00, bank_select);
        set_bank(8'h17, 8'h01);
        ops = '{8'h0D, 8'hBD, 8'hED, 8'h02, 8'h32, 8'h20, 8'hD8};
        foreach (ops[i]) begin
            a = $random(seed);
            note(ops[i], {8'h01, a[23:0]});
            u_sfod_host.frame('{ops[i], a[23:16], a[15:8], a[7:0]});
        end
        ops = '{8'h90, 8'h9F, 8'hAB, 8'h41, 8'h43, 8'h4A};
        foreach (ops[i]) begin
            note(ops[i], 32'h0);
            u_sfod_host.frame('{ops[i]});
        end
        a = $random(seed);
        note(8'h18, a);
        u_sfod_host.frame('{8'h18, a[31:24], a[23:16], a[15:8], a[7:0]});
        u_sfod_host.frame('{8'hE5, 8'h17, 8'h05});
        chk_reg(8'h01, bank_select);
        set_bank(8'hB9, 8'h80);
        note(8'h0B, 32'h00FFFFFF);
        u_sfod_host.frame('{8'h0B, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00});
        chk_val({17'h0, 32'h01000001}, {17'h0, read_addr});
        chk_reg(8'h80, bank_select);
        set_bank(8'h17, 8'h01);
        note(8'h16, 32'h0);
        u_sfod_host.frame('{8'h16, 8'h00});
        chk_reg(8'h01, u_sfod_host.rx);
        wait_empty;
        hold = 1'b1;
        ops = '{8'h02, 8'h00, 8'hFF, 8'hF0};
        note(8'h02, 32'h0100FFF0);
        for (int i = 0; i < 33; i++) begin
            ops.push_back(8'($random(seed)));
            if (i < 31) note(8'h02, 32'h0100FFF0 + i, KIND_DATA, ops[i + 4]);
        end
        u_sfod_host.frame(ops);
        chk_reg(8'h01, {7'h0, overrun});
        hold = 1'b0;
        wait_empty;
        @(posedge clk) #1 overrun_clr = 1'b1;
        @(posedge clk) #1 overrun_clr = 1'b0;
        @(posedge clk);
        chk_reg(8'h00, {7'h0, overrun});
        chk_val('0, 49'(q.size()));
        test_done;
    end
endmodule : sfod_top_tb
